// ===== pkg/acr_pkg.sv
// Contract
// - 24-bit threshold split across two registers
// - 4-bit global dc filter setting, resets zero
// - reserved fields read only, always zero
// - chan0 dc filter off bit overrides global
// - chan0 input select four codes, default 00
// - 10-bit signed phase delay, resets zero
// - 24-bit offset split across two registers
// - gain upper register resets to 8000h
// - other registers reset to 0000h
// - threshold used only with current detect on
package acr_pkg;
    // register indices (word offsets)
    localparam logic [7:0] OFS_GLOBAL_CFG = 8'h06;
    localparam logic [7:0] OFS_THR_HIGH = 8'h07;
    localparam logic [7:0] OFS_THR_LOW = 8'h08;
    localparam logic [7:0] OFS_CHAN0_CONFIG = 8'h09;
    localparam logic [7:0] OFS_OFF_HIGH = 8'h0A;
    localparam logic [7:0] OFS_OFF_LOW = 8'h0B;
    localparam logic [7:0] OFS_GAIN_HIGH = 8'h0C;
    // reset values
    localparam logic [15:0] RST_ZERO = 16'h0000;
    localparam logic [15:0] RST_GAIN_HIGH = 16'h8000;
    // writable masks (reserved bits clear)
    localparam logic [15:0] MASK_THR_LOW = 16'hFF0F;
    localparam logic [15:0] MASK_CHAN0_CONFIG = 16'hFFC7;
    localparam logic [15:0] MASK_OFF_LOW = 16'hFF00;
    localparam logic [15:0] MASK_GLOBAL_CFG = 16'h0001;
    // field positions
    localparam int POS_PHASE = 6;
    localparam int POS_DC_OFF = 2;
    localparam int POS_CD_ON = 0;
    // input select codes
    typedef enum logic [1:0] {
        ACR_IN_PAIR = 2'h0,
        ACR_IN_SHORT = 2'h1,
        ACR_IN_TEST_POS = 2'h2,
        ACR_IN_TEST_NEG = 2'h3
    } acr_insel_type;
    // configuration handed to the datapath
    typedef struct packed {
        logic [23:0] threshold;
        logic threshold_valid;
        logic [3:0] global_dc_filter_setting;
        logic [3:0] chan0_dc_filter_eff;
        logic [9:0] chan0_phase_delay;
        acr_insel_type chan0_input_select;
        logic [23:0] chan0_offset;
        logic [15:0] chan0_gain_upper;
    } acr_cfg_type;
endpackage : acr_pkg

// ===== verilog/acr_reg16.sv
`timescale 1ns/10ps
`default_nettype none
// one 16-bit register with writable mask and reset value
module acr_reg16
    import acr_pkg::*;
#(
    parameter logic [15:0] RESET_VALUE = 16'h0000,
    parameter logic [15:0] WRITE_MASK = 16'hFFFF
)
(
    input wire logic clk_sys, // system clock
    input wire logic rst_n, // async reset, active low
    input wire logic wr_en, // write this register
    input wire logic [15:0] wr_data, // write data
    output logic [15:0] value_q // current contents
);
    // masked bits stay zero whatever is written
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            value_q <= RESET_VALUE & WRITE_MASK;
        end
        else if (wr_en)
        begin
            value_q <= wr_data & WRITE_MASK;
        end
    end
endmodule : acr_reg16
`default_nettype wire

// ===== verilog/acr_regs.sv
`timescale 1ns/10ps
`default_nettype none
// threshold, channel 0 config and calibration registers
module acr_regs
    import acr_pkg::*;
(
    input wire logic clk_sys, // system clock, 50 MHz
    input wire logic rst_n, // async reset, active low
    input wire logic [7:0] reg_addr, // register index
    input wire logic [15:0] reg_wdata, // write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    output logic [15:0] reg_rdata, // read data, cycle after strobe
    output acr_cfg_type cfg // decoded settings for datapath
);
    localparam int NREG = 7; // registers held here
    // per-register index, mask and reset tables
    localparam logic [7:0] IDX [NREG] = '{OFS_GLOBAL_CFG, OFS_THR_HIGH,
        OFS_THR_LOW, OFS_CHAN0_CONFIG, OFS_OFF_HIGH, OFS_OFF_LOW, OFS_GAIN_HIGH};
    localparam logic [15:0] MASK [NREG] = '{MASK_GLOBAL_CFG, 16'hFFFF,
        MASK_THR_LOW, MASK_CHAN0_CONFIG, 16'hFFFF, MASK_OFF_LOW, 16'hFFFF};
    localparam logic [15:0] RSTV [NREG] = '{RST_ZERO, RST_ZERO, RST_ZERO,
        RST_ZERO, RST_ZERO, RST_ZERO, RST_GAIN_HIGH};

    logic [15:0] val [NREG]; // register contents
    logic [15:0] rd_mux; // combinational read value
    logic [15:0] rdata_q; // registered read data

    // one register per entry
    for (genvar i = 0; i < NREG; i++)
    begin : g_reg
        acr_reg16 #(
            .RESET_VALUE(RSTV[i]),
            .WRITE_MASK(MASK[i])
        ) u_reg (
            .clk_sys(clk_sys),
            .rst_n(rst_n),
            .wr_en(reg_wr && (reg_addr == IDX[i])),
            .wr_data(reg_wdata),
            .value_q(val[i])
        );
    end

    // read select, unmapped reads zero
    always_comb
    begin
        rd_mux = 16'h0000;
        for (int k = 0; k < NREG; k++)
        begin
            if (reg_addr == IDX[k])
            begin
                rd_mux = val[k];
            end
        end
    end

    // read data valid only the cycle after the strobe
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdata_q <= 16'h0000;
        end
        else
        begin
            rdata_q <= reg_rd ? rd_mux : 16'h0000;
        end
    end
    assign reg_rdata = rdata_q;

    // settings toward the datapath
    always_comb
    begin
        cfg.threshold = {val[1], val[2][15:8]};
        cfg.threshold_valid = val[0][POS_CD_ON];
        cfg.global_dc_filter_setting = val[2][3:0];
        // dc filter off forces code zero for chan0
        cfg.chan0_dc_filter_eff = val[3][POS_DC_OFF] ? 4'h0 : val[2][3:0];
        cfg.chan0_phase_delay = val[3][15:POS_PHASE];
        cfg.chan0_input_select = acr_insel_type'(val[3][1:0]);
        cfg.chan0_offset = {val[4], val[5][15:8]};
        cfg.chan0_gain_upper = val[6];
        if (!val[0][POS_CD_ON])
        begin
            cfg.threshold = 24'h000000;
        end
    end

    // gain upper at reset value right after reset
    AST_GAIN_RESET: assert property (@(posedge clk_sys) $rose(rst_n) |-> val[6] == 16'h8000)
        else $error("gain upper not 8000h after reset");
    AST_THR_ZERO: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(rst_n) |-> val[1] == 16'h0000 && val[2] == 16'h0000)
        else $error("threshold not zero after reset");
    AST_RSV_LOW: assert property (@(posedge clk_sys) disable iff (!rst_n)
        val[5][7:0] == 8'h00)
        else $error("offset low reserved bits set");
    AST_RSV_CFG: assert property (@(posedge clk_sys) disable iff (!rst_n)
        reg_wr && reg_addr == OFS_CHAN0_CONFIG |=> val[3][5:3] == 3'h0)
        else $error("config reserved bits written");
    AST_THR_WRITE: assert property (@(posedge clk_sys) disable iff (!rst_n)
        reg_wr && reg_addr == OFS_THR_LOW |=> val[2][15:8] == $past(reg_wdata[15:8]))
        else $error("threshold low bits not stored");
    AST_DC_OFF: assert property (@(posedge clk_sys) disable iff (!rst_n)
        val[3][2] |-> cfg.chan0_dc_filter_eff == 4'h0)
        else $error("dc filter not off");
    AST_CD_GATE: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !val[0][0] |-> cfg.threshold == 24'h000000)
        else $error("threshold used while detect off");
    AST_RD_DATA: assert property (@(posedge clk_sys) disable iff (!rst_n)
        reg_rd && reg_addr == OFS_OFF_HIGH && !reg_wr |=> reg_rdata == $past(val[4]))
        else $error("offset high read mismatch");
    AST_PHASE: assert property (@(posedge clk_sys) disable iff (!rst_n)
        reg_wr && reg_addr == OFS_CHAN0_CONFIG |=> cfg.chan0_phase_delay == $past(reg_wdata[15:6]))
        else $error("phase delay not stored");
endmodule : acr_regs
`default_nettype wire

// ===== verif/acr_regs_tb.sv
`timescale 1ns/10ps
`default_nettype none
// compare one design value against its expectation, count and report
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin num_errors++; \
    $display("BAD %0t %h %h", $time, (a), (e)); end end
module acr_regs_tb
    import acr_pkg::*;
;
    logic clk_sys = 1'b0; // 50 MHz clock
    logic rst_n = 1'b0; // async reset, active low
    logic [7:0] reg_addr = 8'h00; // register index
    logic [15:0] reg_wdata = 16'h0000; // write data
    logic reg_wr = 1'b0; // write strobe
    logic reg_rd = 1'b0; // read strobe
    logic [15:0] reg_rdata; // read data
    acr_cfg_type cfg; // decoded settings
    int num_errors = 0; // mismatches
    int comparisons = 0; // checks made
    int cycles = 0; // hang guard
    acr_regs DUT (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cfg(cfg));
    // clock generator
    always #10 clk_sys = ~clk_sys;
    // verdict and end of run
    task test_done;
        if (num_errors == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : test_done
    // cut short a hung run
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            num_errors++;
            test_done();
        end
    end
    // one write cycle, then one idle cycle
    task wr(input logic [7:0] a, input logic [15:0] d);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        @(posedge clk_sys);
    endtask : wr
    // one read cycle, data checked in the following cycle
    task rd(input logic [7:0] a, input logic [15:0] e);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 `CHK(reg_rdata, e)
        @(posedge clk_sys);
    endtask : rd
    // reset contents of every register
    task t_reset;
        for (int i = 6; i < 12; i++)
            rd(i[7:0], 16'h0000);
        rd(8'h0C, 16'h8000);
        `CHK(cfg.chan0_gain_upper, 16'h8000)
    endtask : t_reset
    // threshold split, dc setting, reserved bits, detect gating
    task t_thresh;
        wr(8'h07, 16'hA5C3);
        wr(8'h08, 16'hFFFF);
        rd(8'h08, 16'hFF0F);
        `CHK(cfg.threshold, 24'h000000)
        `CHK(cfg.threshold_valid, 1'b0)
        `CHK(cfg.global_dc_filter_setting, 4'hF)
        wr(8'h06, 16'h0001);
        `CHK(cfg.threshold, 24'hA5C3FF)
        `CHK(cfg.threshold_valid, 1'b1)
    endtask : t_thresh
    // phase, dc filter override and every input select code
    task t_chan;
        wr(8'h09, 16'hFFFF);
        rd(8'h09, 16'hFFC7);
        `CHK(cfg.chan0_phase_delay, 10'h3FF)
        `CHK(cfg.chan0_dc_filter_eff, 4'h0)
        for (int i = 0; i < 4; i++)
        begin
            wr(8'h09, {14'h0000, i[1:0]});
            `CHK(cfg.chan0_input_select, i[1:0])
            `CHK(cfg.chan0_dc_filter_eff, 4'hF)
        end
    endtask : t_chan
    // offset split and an unmapped index
    task t_offs;
        wr(8'h0A, 16'h8001);
        wr(8'h0B, 16'hFFFF);
        rd(8'h0B, 16'hFF00);
        `CHK(cfg.chan0_offset, 24'h8001FF)
        wr(8'h20, 16'hFFFF);
        rd(8'h20, 16'h0000);
    endtask : t_offs
    // mid-run reset brings back gain upper, threshold low and detect off defaults
    task t_rst;
        wr(8'h0C, 16'h1234);
        `CHK(cfg.chan0_gain_upper, 16'h1234)
        rst_n <= 1'b0;
        @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        `CHK(cfg.threshold_valid, 1'b0)
        rd(8'h0C, 16'h8000);
        rd(8'h08, 16'h0000);
    endtask : t_rst
    // main sequence
    initial
    begin
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        t_reset();
        t_thresh();
        t_chan();
        t_offs();
        t_rst();
        test_done();
    end
endmodule : acr_regs_tb
`default_nettype wire
